// [core/result_formats_defs.svh]
// constants for the monitor result register formatting block
// What this block does
// - a fresh result written into a register pair sets the fresh flag in bit 7 of its upper byte.
// - the host addressing an upper byte for reading clears that result's fresh flag.
// - a diode voltage upper byte holds the flag in bit 7, zeros in bits 6 and 5, result bits 12 to 8 below.
// - a diode voltage lower byte holds result bits 7 to 0.
// - the 9-bit pulse threshold keeps bits 8 to 1 in its own register and bit 0 in the control register.
// - single-ended voltages are a sign plus 14 bits in two's complement at 2.5 V over 2^13 per step.
// - differential voltages are a sign plus 14 bits in two's complement at 2.5 V over 2^17 per step.
// - the supply result is the supply minus 2.5 V at the single-ended step.
// - temperatures are 13 bits at 1/16 degree, Celsius signed and Kelvin unsigned.
// - remote diode voltages are an unsigned 13-bit magnitude with no sign, zero input leaves both bytes zero apart from the fresh flag.
// - a voltage or current upper byte holds the flag in bit 7, sign in bit 6, result bits 13 to 8 below.
// - bit 7 of the control register holds threshold bit 0 and resets to zero.
`ifndef RESULT_FORMATS_DEFS_SVH
`define RESULT_FORMATS_DEFS_SVH
`define FRESH_BIT 7
`define SIGN_BIT 6
`define THR_LSB_BIT 7
`define CTRL_RESET 8'h00
`define THR_RESET 8'h00
`define PAIR_RESET 8'h00
`define PULSE_RESET 9'h000
`define NUM_RESULTS 10
`define SUPPLY_SLOT 9
`define DIE_SLOT 8
// supply offset 2.5 V in single-ended steps (2.5 / (2.5/2^13))
`define SUPPLY_OFFSET 15'h2000
`endif

// [core/result_formats_pkg.sv]
// types for the monitor result register formatting block
package result_formats_pkg;
   typedef enum logic [2:0] {
      fmt_single = 3'b000,
      fmt_diff = 3'b001,
      fmt_supply = 3'b010,
      fmt_celsius = 3'b011,
      fmt_kelvin = 3'b100,
      fmt_diode = 3'b101
   } result_fmt_t;
   typedef struct packed {
      logic valid;
      logic [3:0] slot;
      result_fmt_t fmt;
      logic signed [15:0] value;
   } conv_result_t;
   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } byte_pair_t;
endpackage

// [core/result_packer.sv]
// formats one raw converter value into its upper and lower bytes
`timescale 1ns/1ps
`include "result_formats_defs.svh"
module result_packer (
   input wire result_formats_pkg::result_fmt_t fmt,
   input wire logic signed [15:0] value,
   output logic [7:0] upper_bits,
   output logic [7:0] lower_bits
);
   import result_formats_pkg::*;
   logic signed [15:0] adj;
   always_comb begin
      adj = value;
      upper_bits = 8'h00;
      lower_bits = 8'h00;
      case (fmt)
         fmt_supply: begin
            adj = value - $signed({1'b0, `SUPPLY_OFFSET});
            upper_bits = {1'b0, adj[15], adj[13:8]};
            lower_bits = adj[7:0];
         end
         fmt_single, fmt_diff: begin
            upper_bits = {1'b0, adj[15], adj[13:8]};
            lower_bits = adj[7:0];
         end
         fmt_celsius, fmt_kelvin: begin
            upper_bits = {3'b000, adj[12:8]};
            lower_bits = adj[7:0];
         end
         fmt_diode: begin
            upper_bits = {3'b000, adj[12:8]};
            lower_bits = adj[7:0];
         end
         default: begin
            upper_bits = 8'h00;
            lower_bits = 8'h00;
         end
      endcase
   end
endmodule

// [core/monitor_result_formats.sv]
// result registers with fresh flags and the split pulse threshold
`timescale 1ns/1ps
`include "result_formats_defs.svh"
module monitor_result_formats (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire result_formats_pkg::conv_result_t conv_in,
   input wire logic rd_upper,
   input wire logic [3:0] rd_slot,
   input wire logic thr_wr,
   input wire logic [7:0] thr_wdata,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   output result_formats_pkg::byte_pair_t rd_data,
   output logic [7:0] pulse_threshold_upper_bits,
   output logic [7:0] ctrl_reg_out,
   output logic [8:0] pulse_threshold,
   output logic [`NUM_RESULTS-1:0] result_fresh_flag
);
   import result_formats_pkg::*;
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] fmt_upper;
   logic [7:0] fmt_lower;
   logic [7:0] upper_reg [`NUM_RESULTS];
   logic [7:0] lower_reg [`NUM_RESULTS];
   logic [7:0] thr_reg;
   logic [7:0] thr_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [`NUM_RESULTS-1:0] store_hit;
   logic [`NUM_RESULTS-1:0] clear_hit;
   logic [`NUM_RESULTS-1:0] addr_hit;
   logic [`NUM_RESULTS-1:0][7:0] pick_upper;
   logic [`NUM_RESULTS-1:0][7:0] pick_lower;
   logic [`NUM_RESULTS-1:0] pick_fresh;
   logic [7:0] sel_upper;
   logic [7:0] sel_lower;
   logic sel_fresh;
   logic slot_in_range;
   logic [7:0] rd_upper_next;
   logic [7:0] rd_lower_next;
   logic [8:0] pulse_threshold_next;
   // ------------------------------------------------------------
   // formatting
   // ------------------------------------------------------------
   // one shared formatter, since at most one result lands per cycle
   result_packer packer (
      .fmt(conv_in.fmt),
      .value(conv_in.value),
      .upper_bits(fmt_upper),
      .lower_bits(fmt_lower)
   );
   // ------------------------------------------------------------
   // per slot logic
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `NUM_RESULTS; i = i + 1) begin : g_slot
         logic [7:0] upper_next;
         logic [7:0] lower_next;
         logic fresh_next;
         assign store_hit[i] = conv_in.valid && (conv_in.slot == 4'(i));
         assign addr_hit[i] = (rd_slot == 4'(i));
         assign clear_hit[i] = rd_upper && addr_hit[i];
         // masked per slot, so no read index runs past the last slot
         assign pick_upper[i] = addr_hit[i] ? upper_reg[i] : 8'h00;
         assign pick_lower[i] = addr_hit[i] ? lower_reg[i] : 8'h00;
         assign pick_fresh[i] = addr_hit[i] && result_fresh_flag[i];
         // ------------------------------------------------------
         // result pair
         // ------------------------------------------------------
         // both bytes come from one result
         always_comb begin
            upper_next = upper_reg[i];
            lower_next = lower_reg[i];
            if (store_hit[i]) begin
               upper_next = fmt_upper;
               lower_next = fmt_lower;
            end
         end
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               upper_reg[i] <= `PAIR_RESET;
            end else if (clk_en) begin
               upper_reg[i] <= upper_next;
            end
         end
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               lower_reg[i] <= `PAIR_RESET;
            end else if (clk_en) begin
               lower_reg[i] <= lower_next;
            end
         end
         // ------------------------------------------------------
         // fresh flag
         // ------------------------------------------------------
         // set wins over read clear, so no result goes unseen
         always_comb begin
            fresh_next = result_fresh_flag[i];
            if (store_hit[i]) begin
               fresh_next = 1'b1;
            end else if (clear_hit[i]) begin
               fresh_next = 1'b0;
            end
         end
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               result_fresh_flag[i] <= 1'b0;
            end else if (clk_en) begin
               result_fresh_flag[i] <= fresh_next;
            end
         end
      end
   endgenerate
   // ------------------------------------------------------------
   // read select
   // ------------------------------------------------------------
   // or of the masked copies; only one slot is ever addressed
   always_comb begin
      sel_upper = 8'h00;
      sel_lower = 8'h00;
      for (int k = 0; k < `NUM_RESULTS; k++) begin
         sel_upper = sel_upper | pick_upper[k];
         sel_lower = sel_lower | pick_lower[k];
      end
   end
   assign sel_fresh = |pick_fresh;
   // slots past the last one read as zero
   assign slot_in_range = (rd_slot < 4'(`NUM_RESULTS));
   // flag shown as it stood when addressed, before the clear lands
   always_comb begin
      rd_upper_next = 8'h00;
      rd_lower_next = 8'h00;
      if (slot_in_range) begin
         rd_upper_next = sel_upper | ({7'h00, sel_fresh} << `FRESH_BIT);
         rd_lower_next = sel_lower;
      end
   end
   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // answer stands one cycle after the slot is presented
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else if (clk_en) begin
         rd_data.upper <= rd_upper_next;
         rd_data.lower <= rd_lower_next;
      end
   end
   // ------------------------------------------------------------
   // pulse threshold
   // ------------------------------------------------------------
   // upper eight bits in own register
   always_comb begin
      thr_next = thr_reg;
      if (thr_wr) begin
         thr_next = thr_wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         thr_reg <= `THR_RESET;
      end else if (clk_en) begin
         thr_reg <= thr_next;
      end
   end
   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   // bits 1 and 0 are reserved and always read as zero
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = {ctrl_wdata[7:2], 2'b00};
      end
   end
   // bit 7 is threshold bit 0, cleared by reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (clk_en) begin
         ctrl_reg <= ctrl_next;
      end
   end
   // nine bits joined from both registers
   assign pulse_threshold_next = {thr_reg, ctrl_reg[`THR_LSB_BIT]};
   // ------------------------------------------------------------
   // output copies
   // ------------------------------------------------------------
   // copies lag the registers by a cycle so every output leaves a flop
   // joined threshold
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulse_threshold <= `PULSE_RESET;
      end else if (clk_en) begin
         pulse_threshold <= pulse_threshold_next;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulse_threshold_upper_bits <= `THR_RESET;
      end else if (clk_en) begin
         pulse_threshold_upper_bits <= thr_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_reg_out <= `CTRL_RESET;
      end else if (clk_en) begin
         ctrl_reg_out <= ctrl_reg;
      end
   end
endmodule

// [test/host_model.sv]
// host model: upper-byte reads and split threshold writes
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output logic rd_upper,
   output logic [3:0] rd_slot,
   output logic thr_wr,
   output logic [7:0] thr_wdata,
   output logic ctrl_wr,
   output logic [7:0] ctrl_wdata
);
   initial {rd_upper, rd_slot, thr_wr, thr_wdata, ctrl_wr, ctrl_wdata} = '0;
   task automatic read_upper(input logic [3:0] s);
      @(posedge clk);
      rd_upper <= 1'b1;
      rd_slot <= s;
      @(posedge clk);
      rd_upper <= 1'b0;
   endtask
   task automatic write_thr(input logic [8:0] v, input logic [6:0] rest);
      @(posedge clk);
      {thr_wr, ctrl_wr} <= 2'b11;
      thr_wdata <= v[8:1];
      ctrl_wdata <= {v[0], rest};
      @(posedge clk);
      {thr_wr, ctrl_wr} <= 2'b00;
   endtask
endmodule

// [test/monitor_result_formats_properties.sv]
// port assertions for the result register block
`timescale 1ns/1ps
module monitor_result_formats_properties
   import result_formats_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire result_formats_pkg::conv_result_t conv_in,
   input wire logic rd_upper,
   input wire logic [3:0] rd_slot,
   input wire logic thr_wr,
   input wire logic [7:0] thr_wdata,
   input wire result_formats_pkg::byte_pair_t rd_data,
   input wire logic [7:0] pulse_threshold_upper_bits,
   input wire logic [7:0] ctrl_reg_out,
   input wire logic [8:0] pulse_threshold,
   input wire logic [9:0] result_fresh_flag
);
   wire logic wr_now = conv_in.valid & clk_en;
   wire logic fl_now = result_fresh_flag[rd_slot];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_thr_wr;
      clk_en && thr_wr ##1 clk_en;
   endsequence
   AST_FRESH_SET: assert property (wr_now && conv_in.slot < 10 |=>
      result_fresh_flag[$past(conv_in.slot)]) else $error("flag not set");
   AST_FRESH_CLR: assert property (clk_en && rd_upper && rd_slot < 10 &&
      !(conv_in.valid && conv_in.slot == rd_slot)
      |=> !result_fresh_flag[$past(rd_slot)]) else $error("flag kept");
   AST_RD_FLAG: assert property (clk_en && rd_slot < 10 |=>
      rd_data.upper[7] == $past(fl_now)) else $error("read flag wrong");
   AST_FLAG_RISE: assert property ((result_fresh_flag &
      ~$past(result_fresh_flag)) != '0 |-> $past(wr_now))
      else $error("flag rose alone");
   AST_FREEZE: assert property (!clk_en |=> $stable(result_fresh_flag))
      else $error("flags moved");
   AST_THR_OUT: assert property (s_thr_wr |=>
      pulse_threshold_upper_bits == $past(thr_wdata, 2))
      else $error("threshold wrong");
   AST_RD_RANGE: assert property (clk_en && rd_slot >= 10 |=>
      rd_data == '0) else $error("out of range read not zero");
   AST_THR_JOIN: assert property (pulse_threshold ==
      {pulse_threshold_upper_bits, ctrl_reg_out[7]}) else $error("join");
   AST_RESET_ZERO: assert property ($rose(reset_n) |->
      ctrl_reg_out == '0 && pulse_threshold == '0) else $error("reset");
endmodule
bind monitor_result_formats monitor_result_formats_properties u_props (.*);

// [test/tb.sv]
// self-checking bench for the result register block
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
   fail_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
   import result_formats_pkg::*;
   typedef struct packed {logic [3:0] s; result_fmt_t f;
      logic [15:0] v; logic [15:0] x;} row_t;
   logic clk = 0, reset_n = 0, clk_en = 1;
   conv_result_t conv_in = '0;
   logic rd_upper, thr_wr, ctrl_wr;
   logic [3:0] rd_slot;
   logic [7:0] thr_wdata, ctrl_wdata, thr_o, ctrl_o;
   byte_pair_t rd_data;
   logic [8:0] thr9;
   logic [9:0] flags;
   int fail_count = 0, check_count = 0;
   row_t rows [8] = '{'{0, fmt_single, 16'h2ccd, 16'haccd},
      '{3, fmt_single, 16'hfc29, 16'hfc29}, '{5, fmt_diff, 16'hdf71, 16'hdf71},
      '{9, fmt_supply, 16'h4ccd, 16'haccd}, '{8, fmt_celsius, 16'h1d80, 16'h9d80},
      '{1, fmt_kelvin, 16'h18e2, 16'h98e2}, '{2, fmt_diode, 16'h7fff, 16'h9fff},
      '{6, fmt_diode, 16'h0000, 16'h8000}};
   always #12.5 clk = ~clk;
   monitor_result_formats u_monitor_result_formats (.clk(clk),
      .reset_n(reset_n), .clk_en(clk_en), .conv_in(conv_in),
      .rd_upper(rd_upper), .rd_slot(rd_slot), .thr_wr(thr_wr),
      .thr_wdata(thr_wdata), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .rd_data(rd_data), .pulse_threshold_upper_bits(thr_o),
      .ctrl_reg_out(ctrl_o), .pulse_threshold(thr9),
      .result_fresh_flag(flags));
   host_model u_host_model (.clk(clk), .rd_upper(rd_upper),
      .rd_slot(rd_slot), .thr_wr(thr_wr), .thr_wdata(thr_wdata),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000 fail_count++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      #1 `CHK("ctrl", 8'h00, ctrl_o)
      foreach (rows[i]) begin
         @(posedge clk);
         conv_in <= '{1'b1, rows[i].s, rows[i].f, rows[i].v};
         @(posedge clk);
         conv_in.valid <= 1'b0;
         u_host_model.read_upper(rows[i].s);
         #1 `CHK("pair", rows[i].x, rd_data)
         `CHK("flag", 1'b0, flags[rows[i].s])
      end
      u_host_model.write_thr(9'h14b, 7'h03);
      repeat (2) @(posedge clk);
      #1 `CHK("thr", 9'h14b, thr9)
      `CHK("thr hi", 8'ha5, thr_o)
      `CHK("ctrl", 8'h80, ctrl_o)
      // set and clear on one edge: the new result must stay fresh
      fork
         u_host_model.read_upper(4'd3);
         begin
            @(posedge clk);
            conv_in <= '{1'b1, 4'd3, fmt_single, 16'h0001};
            @(posedge clk);
            conv_in.valid <= 1'b0;
         end
      join
      #1 `CHK("set wins", 1'b1, flags[3])
      @(posedge clk);
      clk_en <= 1'b0;
      conv_in <= '{1'b1, 4'd4, fmt_single, 16'h0001};
      @(posedge clk);
      conv_in.valid <= 1'b0;
      clk_en <= 1'b1;
      #1 `CHK("frozen", 1'b0, flags[4])
      u_host_model.read_upper(4'd12);
      #1 `CHK("out of range", 16'h0000, rd_data)
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      #1 `CHK("thr reset", 9'h000, thr9)
      `CHK("flags reset", 10'h000, flags)
      stop_test();
   end
endmodule
